// *** rtl/pfo_top.sv ***
// Pulse-width and shared-frequency output generator for the io pins
// Operation
// - PWM frequency programmable, up to 1 MHz
// - PWM duty programmable from 0% to 100%
// - Duty resolution equals period in microsecond steps
// - PWM selectable on every general io pin
// - Counters run waveforms without processor help
// - Shared frequency 0 Hz to 4 MHz, square when mark is zero
// - Up to 16 pins share frequency, own duty
`timescale 1ns/100ps
module pfo_top
  import pfo_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [1:0] fn_sel_in [PIN_N],
  input wire logic [PIN_N-1:0] gpio_val_in,
  input wire logic [PIN_N-1:0] gpio_oe_in,
  input wire logic [PW-1:0] pwm_period_us_in,
  input wire logic [PW-1:0] pwm_duty_in [PIN_N],
  input wire logic [FW-1:0] shared_frequency_output_period_in,
  input wire logic [FW-1:0] shared_frequency_output_mark_in [SHARED_FREQUENCY_OUTPUT_PIN_N],
  output logic [PIN_N-1:0] general_io_pin_out,
  output logic [PIN_N-1:0] general_io_pin_oe_out,
  output logic pwm_wrap_out
);
  localparam int TICK_GAP = TICK_CYC - 1;

  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [PW-1:0] pwm_cnt;
  logic [PW-1:0] pwm_per;
  logic [PW-1:0] next_pwm_per;
  logic pwm_wrap;
  logic [FW-1:0] fq_cnt;
  logic [FW-1:0] fq_per;
  logic [FW-1:0] next_fq_per;
  logic fq_run;
  logic fq_wrap;

  // One microsecond step enable from the 40 MHz clock
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      tick_cnt <= TICK_ZERO;
    else if (tick_cnt == TICK_LAST)
      tick_cnt <= TICK_ZERO;
    else
      tick_cnt <= tick_cnt + 6'h01;
  end

  assign tick = (tick_cnt == TICK_LAST);

  // Period below one step would exceed the top PWM rate
  assign next_pwm_per = (pwm_period_us_in < PWM_MIN_PER) ?
                        PWM_MIN_PER : pwm_period_us_in;
  // Greater-or-equal also recovers when a shorter period lands mid-count
  assign pwm_wrap = tick && (pwm_cnt >= pwm_per - PW_ONE);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pwm_cnt <= PW_ZERO;
      pwm_per <= PWM_MIN_PER;
    end
    else if (pwm_wrap)
    begin
      pwm_cnt <= PW_ZERO;
      pwm_per <= next_pwm_per;
    end
    else if (tick)
      pwm_cnt <= pwm_cnt + PW_ONE;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      pwm_wrap_out <= 1'b0;
    else
      pwm_wrap_out <= pwm_wrap;
  end

  // Shared frequency: zero period stops it, short periods clamp to 4 MHz
  assign next_fq_per = (shared_frequency_output_period_in == FW_ZERO) ? FW_ZERO :
                       (shared_frequency_output_period_in < SHARED_FREQUENCY_OUTPUT_MIN_PER) ? SHARED_FREQUENCY_OUTPUT_MIN_PER :
                       shared_frequency_output_period_in;
  assign fq_run = (fq_per != FW_ZERO);
  assign fq_wrap = fq_run && (fq_cnt >= fq_per - FW_ONE);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      fq_cnt <= FW_ZERO;
      fq_per <= FW_ZERO;
    end
    else if (fq_wrap || !fq_run)
    begin
      fq_cnt <= FW_ZERO;
      fq_per <= next_fq_per;
    end
    else
      fq_cnt <= fq_cnt + FW_ONE;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_pin
      pfo_chan #(
        .SHARED_FREQUENCY_OUTPUT_OK(gi < SHARED_FREQUENCY_OUTPUT_PIN_N)
      ) u_chan (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .fn_in(fn_sel_in[gi]),
        .gpio_val_in(gpio_val_in[gi]),
        .gpio_oe_in(gpio_oe_in[gi]),
        .pwm_cnt_in(pwm_cnt),
        .pwm_per_in(pwm_per),
        .pwm_wrap_in(pwm_wrap),
        .pwm_duty_in(pwm_duty_in[gi]),
        .fq_cnt_in(fq_cnt),
        .fq_half_in(fq_per >> 1),
        .fq_run_in(fq_run),
        .fq_wrap_in(fq_wrap),
        .fq_mark_in(gi < SHARED_FREQUENCY_OUTPUT_PIN_N ?
                    shared_frequency_output_mark_in[gi % SHARED_FREQUENCY_OUTPUT_PIN_N] : FW_ZERO),
        .pin_out(general_io_pin_out[gi]),
        .oe_out(general_io_pin_oe_out[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_step;
    tick ##1 !tick;
  endsequence

  sequence s_wrap_restart;
    pwm_wrap ##1 (pwm_cnt == PW_ZERO);
  endsequence

  chk_step_spacing: assert property (
    tick |-> s_step ##TICK_GAP tick)
    else $error("microsecond step spacing wrong");

  chk_pwm_restart: assert property (
    pwm_wrap |-> s_wrap_restart)
    else $error("pwm counter did not restart after wrap");

  chk_pwm_range: assert property (
    pwm_cnt < pwm_per || $past(pwm_per) != pwm_per)
    else $error("pwm counter beyond period");

  chk_pwm_rate_cap: assert property (
    pwm_per >= PWM_MIN_PER)
    else $error("pwm period below one step");

  chk_shared_frequency_output_rate_cap: assert property (
    fq_run |-> fq_per >= SHARED_FREQUENCY_OUTPUT_MIN_PER)
    else $error("frequency above the top rate");

  chk_shared_frequency_output_restart: assert property (
    fq_wrap |=> fq_cnt == FW_ZERO ##1 fq_cnt == FW_ONE || !fq_run)
    else $error("frequency counter did not restart");
endmodule

// *** rtl/pfo_pkg.sv ***
// Shared constants for the pulse-width and shared-frequency output block
package pfo_pkg;
  localparam int PIN_N = 19;
  localparam int SHARED_FREQUENCY_OUTPUT_PIN_N = 16;
  localparam int CLK_HZ = 40_000_000;
  localparam int STEP_US = 1;
  localparam int TICK_CYC = (CLK_HZ / 1_000_000) * STEP_US;
  localparam int TICK_W = 6;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam int PWM_MAX_HZ = 1_000_000;
  localparam int PW = 16;
  localparam logic [PW-1:0] PWM_MIN_PER = PW'(1_000_000 / PWM_MAX_HZ);
  localparam int SHARED_FREQUENCY_OUTPUT_MAX_HZ = 4_000_000;
  localparam int FW = 24;
  localparam logic [FW-1:0] SHARED_FREQUENCY_OUTPUT_MIN_PER = FW'(CLK_HZ / SHARED_FREQUENCY_OUTPUT_MAX_HZ);
  localparam logic [PW-1:0] PW_ZERO = 16'h0000;
  localparam logic [PW-1:0] PW_ONE = 16'h0001;
  localparam logic [FW-1:0] FW_ZERO = 24'h000000;
  localparam logic [FW-1:0] FW_ONE = 24'h000001;
  localparam logic [TICK_W-1:0] TICK_ZERO = 6'h00;
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_PWM = 2'h1;
  localparam logic [1:0] FN_SHARED_FREQUENCY_OUTPUT = 2'h2;
endpackage

// *** rtl/pfo_chan.sv ***
// One general io pin: function select, duty shadows and output flops
`timescale 1ns/100ps
module pfo_chan
  import pfo_pkg::*;
#(
  parameter bit SHARED_FREQUENCY_OUTPUT_OK = 1'b1
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [1:0] fn_in,
  input wire logic gpio_val_in,
  input wire logic gpio_oe_in,
  input wire logic [PW-1:0] pwm_cnt_in,
  input wire logic [PW-1:0] pwm_per_in,
  input wire logic pwm_wrap_in,
  input wire logic [PW-1:0] pwm_duty_in,
  input wire logic [FW-1:0] fq_cnt_in,
  input wire logic [FW-1:0] fq_half_in,
  input wire logic fq_run_in,
  input wire logic fq_wrap_in,
  input wire logic [FW-1:0] fq_mark_in,
  output logic pin_out,
  output logic oe_out
);
  logic [PW-1:0] pwm_duty;
  logic [FW-1:0] fq_mark;
  logic pwm_level;
  logic fq_level;
  logic [FW-1:0] mark_eff;

  // Duty only changes at a period boundary, so no runt pulses
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      pwm_duty <= PW_ZERO;
    else if (pwm_wrap_in)
      pwm_duty <= pwm_duty_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      fq_mark <= FW_ZERO;
    else if (fq_wrap_in || !fq_run_in)
      fq_mark <= fq_mark_in;
  end

  // Zero mark means the default square wave
  assign mark_eff = (fq_mark == FW_ZERO) ? fq_half_in : fq_mark;
  // Duty at or above the period keeps the compare true all period
  assign pwm_level = (pwm_cnt_in < pwm_duty);
  assign fq_level = fq_run_in && (fq_cnt_in < mark_eff);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pin_out <= 1'b0;
      oe_out <= 1'b0;
    end
    else
    begin
      case (fn_in)
        FN_PWM:
        begin
          pin_out <= pwm_level;
          oe_out <= 1'b1;
        end
        FN_SHARED_FREQUENCY_OUTPUT:
        begin
          pin_out <= SHARED_FREQUENCY_OUTPUT_OK ? fq_level : gpio_val_in;
          oe_out <= SHARED_FREQUENCY_OUTPUT_OK ? 1'b1 : gpio_oe_in;
        end
        default:
        begin
          pin_out <= gpio_val_in;
          oe_out <= gpio_oe_in;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  chk_pwm_zero_low: assert property (
    (fn_in == FN_PWM && pwm_duty == PW_ZERO && !pwm_wrap_in) |=> !pin_out)
    else $error("pwm pin high with zero duty");

  chk_pwm_full_high: assert property (
    (fn_in == FN_PWM && pwm_duty >= pwm_per_in && !pwm_wrap_in)
    |=> pin_out)
    else $error("pwm pin low with full duty");

  chk_shared_frequency_output_stop_low: assert property (
    (fn_in == FN_SHARED_FREQUENCY_OUTPUT && SHARED_FREQUENCY_OUTPUT_OK && !fq_run_in) |=> !pin_out)
    else $error("frequency pin moves while stopped");

  chk_alt_fn_drive: assert property (
    (fn_in == FN_PWM) |=> oe_out)
    else $error("pwm pin not driven");
endmodule

// *** sim/pfo_load.sv ***
// Pin loads with pull-downs seen by the io pins
`timescale 1ns/100ps
module pfo_load
  import pfo_pkg::*;
(
  input wire logic [PIN_N-1:0] pin_in,
  input wire logic [PIN_N-1:0] oe_in,
  output logic [PIN_N-1:0] level_out
);
  // A released pin sinks to its pull-down, never keeps the last value
  assign level_out = pin_in & oe_in;
endmodule

// *** sim/tb.sv ***
// Self-checking bench: pin waveforms against a counting model
`timescale 1ns/100ps
module tb
  import pfo_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [1:0] fn [PIN_N];
  logic [PIN_N-1:0] gv, go, pins, oes, lvl;
  logic [PW-1:0] per;
  logic [PW-1:0] duty [PIN_N];
  logic [FW-1:0] fper;
  logic [FW-1:0] mark [SHARED_FREQUENCY_OUTPUT_PIN_N];
  logic wrap;
  logic [31:0] hi [PIN_N];
  logic [31:0] on [PIN_N];
  logic [31:0] nw;
  int n_fail = 0;
  int total_checks = 0;
  int t, i, k, f, pe;
  // Last pass asks for a zero period, which must act as one step
  int ph [6] = '{2, 1, 10, 5, 2, 0};
  int fh [6] = '{10, 4, 25, 0, 40, 20};

  pfo_top dut (.clk_in(clk_in), .srst_in(srst_in), .fn_sel_in(fn),
    .gpio_val_in(gv), .gpio_oe_in(go), .pwm_period_us_in(per),
    .pwm_duty_in(duty), .shared_frequency_output_period_in(fper), .shared_frequency_output_mark_in(mark),
    .general_io_pin_out(pins), .general_io_pin_oe_out(oes),
    .pwm_wrap_out(wrap));
  pfo_load ld (.pin_in(pins), .oe_in(oes), .level_out(lvl));

  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for the period restart pulse
  task automatic wait_wrap;
    for (k = 0; k < 2000 && wrap !== 1'b1; k++)
      @(negedge clk_in);
    if (k == 2000)
    begin
      n_fail++;
      close_out();
    end
    else
      @(negedge clk_in);
  endtask

  // High cycles expected in a 400-cycle window, one per pin
  function automatic int exp_hi(int p);
    int d;
    d = int'(duty[p]);
    if (fn[p] == FN_PWM)
      return (d >= pe ? pe : d) * 400 / pe;
    if (fn[p] == FN_SHARED_FREQUENCY_OUTPUT && p < SHARED_FREQUENCY_OUTPUT_PIN_N)
      return f == 0 ? 0 : (mark[p] == 0 ? f / 2 : int'(mark[p])) * 400 / f;
    return (gv[p] & go[p]) ? 400 : 0;
  endfunction

  initial
  begin
    void'($urandom(55));
    per = PW_ONE;
    fper = FW_ZERO;
    gv = '0;
    go = '0;
    for (i = 0; i < PIN_N; i++)
    begin
      fn[i] = FN_GPIO;
      duty[i] = PW_ZERO;
      if (i < SHARED_FREQUENCY_OUTPUT_PIN_N)
        mark[i] = FW_ZERO;
    end
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    for (t = 0; t < 6; t++)
    begin
      @(posedge clk_in);
      f = fh[t] == 0 ? 0 : (fh[t] < 10 ? 10 : fh[t]);
      pe = ph[t] == 0 ? 1 : ph[t];
      per <= PW'(ph[t]);
      fper <= FW'(fh[t]);
      gv <= PIN_N'($urandom);
      go <= PIN_N'($urandom);
      // Pin 0 at zero duty, pin 1 at full duty, pin 2 on the shared rate
      for (i = 0; i < PIN_N; i++)
      begin
        if (i < 2)
          fn[i] <= FN_PWM;
        else if (i == 2)
          fn[i] <= FN_SHARED_FREQUENCY_OUTPUT;
        else
          fn[i] <= 2'($urandom % 4);
        if (i == 0)
          duty[i] <= PW_ZERO;
        else if (i == 1)
          duty[i] <= PW'(pe);
        else
          duty[i] <= PW'($urandom % (ph[t] + 2));
        if (i < SHARED_FREQUENCY_OUTPUT_PIN_N)
          mark[i] <= f == 0 ? FW_ZERO : FW'($urandom % f);
      end
      // Period, duty and mark are taken at period ends, mark also while the shared rate is stopped, so let two pass
      wait_wrap();
      wait_wrap();
      nw = '0;
      for (i = 0; i < PIN_N; i++)
      begin
        hi[i] = '0;
        on[i] = '0;
      end
      repeat (400)
      begin
        @(negedge clk_in);
        nw += 32'(wrap === 1'b1);
        for (i = 0; i < PIN_N; i++)
        begin
          hi[i] += 32'(lvl[i] === 1'b1);
          on[i] += 32'(oes[i] === 1'b1);
        end
      end
      check(nw, 32'(10 / pe));
      for (i = 0; i < PIN_N; i++)
      begin
        check(hi[i], 32'(exp_hi(i)));
        if (fn[i] == FN_PWM || (fn[i] == FN_SHARED_FREQUENCY_OUTPUT && i < SHARED_FREQUENCY_OUTPUT_PIN_N))
          check(on[i], 32'd400);
        else
          check(on[i], go[i] ? 32'd400 : 32'd0);
      end
      $display("test %0d done", t);
    end
    close_out();
  end
endmodule
